// ---- hdl/scc_cfg.svh ----
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// Register byte offsets on the APB window.
`define SCC_OFS_RAW_STATUS 12'h050
`define SCC_OFS_IRQ_MASK 12'h054
`define SCC_OFS_IRQ_CLEAR 12'h058
`define SCC_OFS_RUN_CFG 12'h060
`define SCC_OFS_PLL_XLAT 12'h064
`define SCC_OFS_RUN_CFG_EXT 12'h070
`define SCC_OFS_RUN_GATE 12'h100
`define SCC_OFS_SLEEP_GATE 12'h110
`define SCC_OFS_DSLEEP_GATE 12'h120
`define SCC_OFS_DSLEEP_CFG 12'h144

// Field positions of the run clock configuration register.
`define SCC_RUN_BYPASS 0
`define SCC_RUN_PLL_POWER_DOWN 1
`define SCC_RUN_CRYSTAL_SELECT_LO 2
`define SCC_RUN_CRYSTAL_SELECT_HI 5
`define SCC_RUN_OSC_LO 6
`define SCC_RUN_OSC_HI 8
`define SCC_RUN_DIV_LO 9
`define SCC_RUN_DIV_HI 12
`define SCC_RUN_USEDIV 13
`define SCC_RUN_AUTOGATE 14

// Field positions of the extended configuration register.
`define SCC_EXT_BYPASS 0
`define SCC_EXT_PLL_POWER_DOWN 1
`define SCC_EXT_OSC_LO 6
`define SCC_EXT_OSC_HI 8
`define SCC_EXT_DIV_LO 9
`define SCC_EXT_DIV_HI 14
`define SCC_EXT_OVERRIDE 31

// Deep-sleep configuration oscillator select field.
`define SCC_DS_OSC_LO 4
`define SCC_DS_OSC_HI 6

// Reset values.
`define SCC_RST_RUN_CFG 32'h0000_6043
`define SCC_RST_RUN_CFG_EXT 32'h0000_0043
`define SCC_RST_GATE 32'h0000_0040
`define SCC_RST_ZERO 32'h0000_0000

// Divider values forced in deep sleep while the PLL was running (divide-by minus one).
`define SCC_DS_DIV_RUN 6'h0F
`define SCC_DS_DIV_EXT 6'h3F

// Relock counter start value, in main oscillator ticks.
`define SCC_RELOCK_START 16'h1200

`endif

// ---- hdl/scc_pkg.sv ----
package scc_pkg;

  typedef enum logic [2:0] {
    SCC_SRC_MAIN = 3'h0,
    SCC_SRC_INT = 3'h1,
    SCC_SRC_INT_DIV4 = 3'h2,
    SCC_SRC_SLOW = 3'h3,
    SCC_SRC_RTC = 3'h7
  } scc_src_t;

  typedef enum logic [1:0] {
    SCC_RUN,
    SCC_SLEEP,
    SCC_DSLEEP,
    SCC_DS_EXIT
  } scc_mode_t;

endpackage

// ---- hdl/scc_relock.sv ----
`timescale 1ns/1ns
`include "scc_cfg.svh"

// Relock timer. Counts main oscillator ticks down from the start value.
module scc_relock import scc_pkg::*; #(
  parameter logic [15:0] START = `SCC_RELOCK_START
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic main_crystal_oscillator_tick_i,
  output logic locked_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic locked_r;
  logic locked_nxt;
  logic busy_r;
  logic busy_nxt;

  // Only a started period may end in a lock, so an idle counter at zero
  // after reset does not report a lock for a PLL that never ran.
  always_comb begin
    cnt_nxt = cnt_r;
    locked_nxt = locked_r;
    busy_nxt = busy_r;
    if (start_i) begin
      cnt_nxt = START; // R8
      locked_nxt = 1'b0; // R25
      busy_nxt = 1'b1;
    end else if (busy_r && main_crystal_oscillator_tick_i) begin
      if (cnt_r == 16'h0000) begin
        locked_nxt = 1'b1; // R25
        busy_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 16'h0001; // R8
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_r <= 16'h0000;
      locked_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      locked_r <= locked_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign locked_o = locked_r;

endmodule

// ---- hdl/scc_top.sv ----
// Summary of operation
// R1 - Internal oscillator clocks from reset onward
// R2 - Six selectable system clock sources
// R3 - Override bit selects extended register fields
// R4 - Crystal change retranslates PLL settings, readable
// R5 - PLL disabled after reset
// R6 - PLL normal drives output, power-down none
// R7 - Relock on crystal change or power-up
// R8 - Relock down counter on main oscillator
// R9 - Stay on oscillator until relock done
// R10 - Lock raw flag plus maskable lock interrupt
// R11 - Software ensures stable source before PLL
// R12 - Software picks crystal within supported range
// R13 - Run mode gates by run registers
// R14 - Sleep stops core, gates by mode
// R15 - Deep-sleep stops core, gates by mode
// R16 - Deep-sleep source main or chosen internal
// R17 - Deep-sleep powers PLL down, forces divider
// R18 - Exit restores clock before enabling clocks
// R19 - Interrupt wakes; sleep only on request
// R20 - Deep-sleep request needs enable bit first
// R21 - Software sets override before extended fields
// R22 - Power-down bit controls PLL power
// R23 - Bypass selects raw oscillator, else PLL
// R24 - Source and divider switches glitch-free
// R25 - Lock flag set at zero, cleared on relock
`timescale 1ns/1ns
`include "scc_cfg.svh"

module scc_top import scc_pkg::*; #(
  parameter int NPER = 32,
  parameter logic [15:0] RELOCK_START = `SCC_RELOCK_START
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_crystal_oscillator_tick_i,
  input wire logic internal_fast_oscillator_tick_i,
  input wire logic slow_osc_tick_i,
  input wire logic rtc_tick_i,
  input wire logic pll_tick_i,
  input wire logic wfi_req_i,
  input wire logic deepsleep_en_i,
  input wire logic wake_irq_i,
  output logic system_clock_out_o,
  output logic core_clk_en_o,
  output logic [NPER-1:0] periph_clk_en_o,
  output logic pll_enable_o,
  output logic [12:0] pll_settings_o,
  output logic main_crystal_oscillator_power_down_o,
  output logic internal_fast_oscillator_power_up_o,
  output logic pll_lock_irq_o,
  output logic [1:0] mode_o
);

  // Crystal number to PLL settings {feedback[7:0], reference[4:0]}.
  function automatic logic [12:0] xlat(input logic [3:0] crystal_select);
    logic [7:0] fb;
    logic [4:0] rf;
    fb = 8'h40 - {4'h0, crystal_select};
    rf = {1'b0, crystal_select} >> 1;
    return {fb, rf};
  endfunction

  function automatic logic pick_tick(input logic [2:0] s, input logic mo, input logic io,
                                     input logic i4, input logic sl, input logic rt);
    logic t;
    t = 1'b0;
    unique case (s)
      SCC_SRC_MAIN: t = mo;
      SCC_SRC_INT: t = io;
      SCC_SRC_INT_DIV4: t = i4;
      SCC_SRC_SLOW: t = sl;
      default: t = rt;
    endcase
    return t;
  endfunction

  logic [31:0] run_cfg_r, run_cfg_nxt;
  logic [31:0] ext_cfg_r, ext_cfg_nxt;
  logic [31:0] ds_cfg_r, ds_cfg_nxt;
  logic [NPER-1:0] run_gate_r, run_gate_nxt;
  logic [NPER-1:0] sleep_gate_r, sleep_gate_nxt;
  logic [NPER-1:0] ds_gate_r, ds_gate_nxt;
  logic irq_mask_r, irq_mask_nxt;
  logic lock_raw_r, lock_raw_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt;
  logic wr_en, rd_hit;

  scc_mode_t mode_r, mode_nxt;
  logic ds_pll_forced_r, ds_pll_forced_nxt;
  logic pll_pd_prev_r;
  logic [3:0] crystal_select_prev_r;
  logic [1:0] idiv_r;
  logic [2:0] sel_src_r, sel_src_nxt;
  logic sel_pll_r, sel_pll_nxt;
  logic [5:0] sel_div_r, sel_div_nxt;
  logic [5:0] div_cnt_r, div_cnt_nxt;
  logic sys_en_r, sys_en_nxt;
  logic core_en_r;
  logic [NPER-1:0] per_en_r;
  logic [12:0] pll_set_r;
  logic pll_en_r, main_crystal_oscillator_pd_r, internal_fast_oscillator_up_r, irq_r, locked_d_r;

  logic ovr, eff_bypass, eff_pll_power_down, pll_pd_now, relock_start, locked, lock_rise;
  logic [2:0] eff_src;
  logic [5:0] eff_div;
  logic cur_tick, idiv_tick;

  // Zero-wait decode is avoided: the answer always comes one cycle into the access phase.
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_hit = 1'b1;
    prdata_nxt = 32'h0000_0000;
    unique case (paddr)
      `SCC_OFS_RAW_STATUS: prdata_nxt = {31'h0, lock_raw_r}; // R10
      `SCC_OFS_IRQ_MASK: prdata_nxt = {31'h0, irq_mask_r};
      `SCC_OFS_IRQ_CLEAR: prdata_nxt = {31'h0, lock_raw_r & irq_mask_r};
      `SCC_OFS_RUN_CFG: prdata_nxt = run_cfg_r;
      `SCC_OFS_PLL_XLAT: prdata_nxt = {19'h0, pll_set_r}; // R4
      `SCC_OFS_RUN_CFG_EXT: prdata_nxt = ext_cfg_r;
      `SCC_OFS_RUN_GATE: prdata_nxt = 32'(run_gate_r);
      `SCC_OFS_SLEEP_GATE: prdata_nxt = 32'(sleep_gate_r);
      `SCC_OFS_DSLEEP_GATE: prdata_nxt = 32'(ds_gate_r);
      `SCC_OFS_DSLEEP_CFG: prdata_nxt = ds_cfg_r;
      default: rd_hit = 1'b0;
    endcase
    pready_nxt = psel && penable && !pready;
    pslverr_nxt = pready_nxt && !rd_hit;
  end

  always_comb begin
    ovr = ext_cfg_r[`SCC_EXT_OVERRIDE];
    eff_bypass = ovr ? ext_cfg_r[`SCC_EXT_BYPASS] : run_cfg_r[`SCC_RUN_BYPASS]; // R3 R23
    eff_pll_power_down = ovr ? ext_cfg_r[`SCC_EXT_PLL_POWER_DOWN] : run_cfg_r[`SCC_RUN_PLL_POWER_DOWN]; // R3 R22
    eff_src = ovr ? ext_cfg_r[`SCC_EXT_OSC_HI:`SCC_EXT_OSC_LO]
                  : run_cfg_r[`SCC_RUN_OSC_HI:`SCC_RUN_OSC_LO]; // R3
    if (ovr) begin
      eff_div = ext_cfg_r[`SCC_EXT_DIV_HI:`SCC_EXT_DIV_LO];
    end else if (run_cfg_r[`SCC_RUN_USEDIV]) begin
      eff_div = {2'b00, run_cfg_r[`SCC_RUN_DIV_HI:`SCC_RUN_DIV_LO]};
    end else begin
      eff_div = 6'h00;
    end
    if (mode_r == SCC_DSLEEP) begin
      eff_src = (ds_cfg_r[`SCC_DS_OSC_HI:`SCC_DS_OSC_LO] == 3'h0) ? 3'(SCC_SRC_MAIN)
                : ds_cfg_r[`SCC_DS_OSC_HI:`SCC_DS_OSC_LO]; // R16
      if (ds_pll_forced_r) begin
        eff_div = ovr ? `SCC_DS_DIV_EXT : `SCC_DS_DIV_RUN; // R17
      end
    end
    pll_pd_now = eff_pll_power_down || ds_pll_forced_r; // R5 R6 R17
    relock_start = (run_cfg_r[`SCC_RUN_CRYSTAL_SELECT_HI:`SCC_RUN_CRYSTAL_SELECT_LO] != crystal_select_prev_r)
                   || (pll_pd_prev_r && !pll_pd_now); // R7
    idiv_tick = internal_fast_oscillator_tick_i && (idiv_r == 2'b11); // R2
    lock_rise = locked && !locked_d_r;
  end

  scc_relock #(
    .START(RELOCK_START)
  ) u_relock (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(relock_start),
    .main_crystal_oscillator_tick_i(main_crystal_oscillator_tick_i),
    .locked_o(locked)
  );

  // Register writes, lock flag and sleep mode sequencing.
  always_comb begin
    run_cfg_nxt = run_cfg_r;
    ext_cfg_nxt = ext_cfg_r;
    ds_cfg_nxt = ds_cfg_r;
    run_gate_nxt = run_gate_r;
    sleep_gate_nxt = sleep_gate_r;
    ds_gate_nxt = ds_gate_r;
    irq_mask_nxt = irq_mask_r;
    lock_raw_nxt = lock_raw_r;
    if (wr_en) begin
      unique case (paddr)
        `SCC_OFS_IRQ_MASK: irq_mask_nxt = pwdata[0];
        `SCC_OFS_IRQ_CLEAR: lock_raw_nxt = lock_raw_r && !pwdata[0];
        `SCC_OFS_RUN_CFG: run_cfg_nxt = pwdata;
        `SCC_OFS_RUN_CFG_EXT: ext_cfg_nxt = pwdata;
        `SCC_OFS_RUN_GATE: run_gate_nxt = pwdata[NPER-1:0];
        `SCC_OFS_SLEEP_GATE: sleep_gate_nxt = pwdata[NPER-1:0];
        `SCC_OFS_DSLEEP_GATE: ds_gate_nxt = pwdata[NPER-1:0];
        `SCC_OFS_DSLEEP_CFG: ds_cfg_nxt = pwdata;
        default: ;
      endcase
    end
    // The set wins over a software clear in the same cycle; a new relock wins over both.
    if (lock_rise && !relock_start) begin
      lock_raw_nxt = 1'b1; // R25 R10
    end
    if (relock_start) begin
      lock_raw_nxt = 1'b0; // R25
    end
    mode_nxt = mode_r;
    ds_pll_forced_nxt = ds_pll_forced_r;
    unique case (mode_r)
      SCC_RUN: begin
        if (wfi_req_i) begin // R19
          if (deepsleep_en_i) begin // R20
            mode_nxt = SCC_DSLEEP;
            ds_pll_forced_nxt = !eff_pll_power_down; // R17
          end else begin
            mode_nxt = SCC_SLEEP; // R14
          end
        end
      end
      SCC_SLEEP: begin
        if (wake_irq_i) begin
          mode_nxt = SCC_RUN; // R19
        end
      end
      SCC_DSLEEP: begin
        if (wake_irq_i) begin
          mode_nxt = SCC_DS_EXIT; // R19
          ds_pll_forced_nxt = 1'b0;
        end
      end
      SCC_DS_EXIT: begin
        // Clocks reopen only once the run source and divider are back in place.
        if (sel_src_r == eff_src && sel_div_r == eff_div
            && sel_pll_r == (!eff_bypass && !pll_pd_now && locked)) begin
          mode_nxt = SCC_RUN; // R18
        end
      end
    endcase
  end

  // Clock selection and division, switched only at the end of a whole output period.
  always_comb begin
    cur_tick = sel_pll_r ? pll_tick_i
               : pick_tick(sel_src_r, main_crystal_oscillator_tick_i, internal_fast_oscillator_tick_i, idiv_tick, slow_osc_tick_i,
                           rtc_tick_i); // R2
    sel_src_nxt = sel_src_r;
    sel_pll_nxt = sel_pll_r;
    sel_div_nxt = sel_div_r;
    div_cnt_nxt = div_cnt_r;
    sys_en_nxt = 1'b0;
    if (cur_tick) begin
      if (div_cnt_r == 6'h00) begin
        sys_en_nxt = 1'b1;
        sel_src_nxt = eff_src; // R24
        sel_pll_nxt = !eff_bypass && !pll_pd_now && locked; // R9 R23
        sel_div_nxt = eff_div; // R24
        div_cnt_nxt = eff_div;
      end else begin
        div_cnt_nxt = div_cnt_r - 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_cfg_r <= `SCC_RST_RUN_CFG;
      ext_cfg_r <= `SCC_RST_RUN_CFG_EXT;
      ds_cfg_r <= `SCC_RST_ZERO;
      run_gate_r <= NPER'(`SCC_RST_GATE);
      sleep_gate_r <= NPER'(`SCC_RST_GATE);
      ds_gate_r <= NPER'(`SCC_RST_GATE);
      irq_mask_r <= 1'b0;
      lock_raw_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode_r <= SCC_RUN;
      ds_pll_forced_r <= 1'b0;
      pll_pd_prev_r <= 1'b1;
      crystal_select_prev_r <= 4'h0;
      idiv_r <= 2'b00;
      sel_src_r <= 3'(SCC_SRC_INT); // R1
      sel_pll_r <= 1'b0;
      sel_div_r <= 6'h00;
      div_cnt_r <= 6'h00;
      sys_en_r <= 1'b0;
      core_en_r <= 1'b0;
      per_en_r <= '0;
      pll_set_r <= 13'h0000;
      pll_en_r <= 1'b0;
      main_crystal_oscillator_pd_r <= 1'b1;
      internal_fast_oscillator_up_r <= 1'b1;
      irq_r <= 1'b0;
      locked_d_r <= 1'b0;
    end else begin
      run_cfg_r <= run_cfg_nxt;
      ext_cfg_r <= ext_cfg_nxt;
      ds_cfg_r <= ds_cfg_nxt;
      run_gate_r <= run_gate_nxt;
      sleep_gate_r <= sleep_gate_nxt;
      ds_gate_r <= ds_gate_nxt;
      irq_mask_r <= irq_mask_nxt;
      lock_raw_r <= lock_raw_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      mode_r <= mode_nxt;
      ds_pll_forced_r <= ds_pll_forced_nxt;
      pll_pd_prev_r <= pll_pd_now;
      crystal_select_prev_r <= run_cfg_r[`SCC_RUN_CRYSTAL_SELECT_HI:`SCC_RUN_CRYSTAL_SELECT_LO];
      idiv_r <= internal_fast_oscillator_tick_i ? idiv_r + 2'b01 : idiv_r;
      sel_src_r <= sel_src_nxt;
      sel_pll_r <= sel_pll_nxt;
      sel_div_r <= sel_div_nxt;
      div_cnt_r <= div_cnt_nxt;
      sys_en_r <= sys_en_nxt;
      core_en_r <= sys_en_nxt && (mode_r == SCC_RUN); // R13 R14 R15
      if (!sys_en_nxt || mode_r == SCC_DS_EXIT) begin
        per_en_r <= '0; // R18
      end else if (mode_r == SCC_SLEEP && run_cfg_r[`SCC_RUN_AUTOGATE]) begin
        per_en_r <= sleep_gate_r; // R14
      end else if (mode_r == SCC_DSLEEP && run_cfg_r[`SCC_RUN_AUTOGATE]) begin
        per_en_r <= ds_gate_r; // R15
      end else begin
        per_en_r <= run_gate_r; // R13
      end
      pll_set_r <= xlat(run_cfg_r[`SCC_RUN_CRYSTAL_SELECT_HI:`SCC_RUN_CRYSTAL_SELECT_LO]); // R4
      pll_en_r <= !pll_pd_now; // R5 R22
      main_crystal_oscillator_pd_r <= (mode_r == SCC_DSLEEP) ? (ds_cfg_r[`SCC_DS_OSC_HI:`SCC_DS_OSC_LO] != 3'h0)
                   : (eff_src != 3'(SCC_SRC_MAIN) && pll_pd_now); // R16
      internal_fast_oscillator_up_r <= (mode_r != SCC_DSLEEP) || (ds_cfg_r[`SCC_DS_OSC_HI:`SCC_DS_OSC_LO] != 3'h0);
      irq_r <= lock_raw_r && irq_mask_r; // R10
      locked_d_r <= locked;
    end
  end

  assign system_clock_out_o = sys_en_r;
  assign core_clk_en_o = core_en_r;
  assign periph_clk_en_o = per_en_r;
  assign pll_enable_o = pll_en_r;
  assign pll_settings_o = pll_set_r;
  assign main_crystal_oscillator_power_down_o = main_crystal_oscillator_pd_r;
  assign internal_fast_oscillator_power_up_o = internal_fast_oscillator_up_r;
  assign pll_lock_irq_o = irq_r;
  assign mode_o = mode_r;

endmodule

// ---- sim/scc_osc_model.sv ----
`timescale 1ns/1ns
// Oscillators as strobes; the PLL only ticks while powered, so a design
// that picks it early sees no clock at all.
module scc_osc_model #(
  parameter int PM = 2,
  parameter int PI = 3,
  parameter int PS = 5,
  parameter int PR = 8
) (
  input wire logic sys_clk_i,
  input wire logic pll_en_i,
  output logic main_crystal_oscillator_tick_o,
  output logic internal_fast_oscillator_tick_o,
  output logic slow_tick_o,
  output logic rtc_tick_o,
  output logic pll_tick_o
);
  int cnt = 0;
  initial {main_crystal_oscillator_tick_o, internal_fast_oscillator_tick_o, slow_tick_o, rtc_tick_o, pll_tick_o} = 5'h0;
  always @(posedge sys_clk_i) begin
    cnt <= cnt + 1;
    main_crystal_oscillator_tick_o <= (cnt % PM == 0);
    internal_fast_oscillator_tick_o <= (cnt % PI == 0);
    slow_tick_o <= (cnt % PS == 0);
    rtc_tick_o <= (cnt % PR == 0);
    pll_tick_o <= pll_en_i;
  end
endmodule

// ---- sim/scc_top_sva.sv ----
`timescale 1ns/1ns
module scc_top_sva import scc_pkg::*; #(
  parameter int NPER = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wfi_req_i,
  input wire logic deepsleep_en_i,
  input wire logic wake_irq_i,
  input wire logic system_clock_out_o,
  input wire logic core_clk_en_o,
  input wire logic [NPER-1:0] periph_clk_en_o,
  input wire logic pll_enable_o,
  input wire logic [1:0] mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  ready_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside answer");
  core_tick_a: assert property (core_clk_en_o |-> system_clock_out_o)
    else $error("core tick without system tick");
  periph_tick_a: assert property (|periph_clk_en_o |-> system_clock_out_o)
    else $error("peripheral tick without system tick");
  core_stop_a: assert property (mode_o != SCC_RUN && $past(mode_o) != SCC_RUN
    |-> !core_clk_en_o) else $error("core ticks while asleep");
  pll_ds_a: assert property (mode_o == SCC_DSLEEP && $past(mode_o) == SCC_DSLEEP
    |-> !pll_enable_o) else $error("pll on in deep sleep");
  sleep_req_a: assert property (mode_o inside {SCC_SLEEP, SCC_DSLEEP}
    && $past(mode_o) == SCC_RUN |-> $past(wfi_req_i)) else $error("sleep without request");
  sleep_kind_a: assert property ($past(wfi_req_i) && !$past(reset_i)
    && $past(mode_o) == SCC_RUN |-> mode_o == ($past(deepsleep_en_i) ? SCC_DSLEEP : SCC_SLEEP))
    else $error("wrong sleep mode");
  sleep_wake_a: assert property (mode_o == SCC_SLEEP && wake_irq_i |=> mode_o == SCC_RUN)
    else $error("no wake from sleep");
  ds_wake_a: assert property (mode_o == SCC_DSLEEP && wake_irq_i |=> mode_o == SCC_DS_EXIT)
    else $error("no exit from deep sleep");
  ds_exit_a: assert property (mode_o == SCC_DS_EXIT && $past(mode_o) == SCC_DS_EXIT
    |-> periph_clk_en_o == '0 && !core_clk_en_o) else $error("clocks on before restore");
  cover property (mode_o == SCC_SLEEP);
  cover property (mode_o == SCC_DS_EXIT);
  cover property (pslverr);
endmodule

// ---- sim/system_clock_control_tb_top.sv ----
`timescale 1ns/1ns
`include "scc_cfg.svh"
module system_clock_control_tb_top import scc_pkg::*;;
  logic sys_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic wfi_req_i = 0, deepsleep_en_i = 0, wake_irq_i = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, periph_clk_en_o, rd, por;
  logic pready, pslverr, system_clock_out_o, core_clk_en_o, pll_enable_o, er;
  logic main_crystal_oscillator_power_down_o, internal_fast_oscillator_power_up_o, pll_lock_irq_o;
  logic main_crystal_oscillator_tick_i, internal_fast_oscillator_tick_i, slow_osc_tick_i, rtc_tick_i, pll_tick_i;
  logic [12:0] pll_settings_o;
  logic [1:0] mode_o;
  int failures = 0, checked = 0, cyc = 0, ns, nc;
  scc_src_t srcs[5] = '{SCC_SRC_INT, SCC_SRC_INT_DIV4, SCC_SRC_SLOW, SCC_SRC_RTC, SCC_SRC_MAIN};
  int rts[5] = '{40, 10, 24, 15, 60};

  scc_top #(.NPER(32), .RELOCK_START(16'h0010)) i_dut (.sys_clk_i, .reset_i, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_crystal_oscillator_tick_i, .internal_fast_oscillator_tick_i,
    .slow_osc_tick_i, .rtc_tick_i, .pll_tick_i, .wfi_req_i, .deepsleep_en_i, .wake_irq_i,
    .system_clock_out_o, .core_clk_en_o, .periph_clk_en_o, .pll_enable_o, .pll_settings_o,
    .main_crystal_oscillator_power_down_o, .internal_fast_oscillator_power_up_o, .pll_lock_irq_o, .mode_o);
  scc_osc_model i_osc (.sys_clk_i, .pll_en_i(pll_enable_o), .main_crystal_oscillator_tick_o(main_crystal_oscillator_tick_i),
    .internal_fast_oscillator_tick_o(internal_fast_oscillator_tick_i), .slow_tick_o(slow_osc_tick_i), .rtc_tick_o(rtc_tick_i),
    .pll_tick_o(pll_tick_i));

  initial forever #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Phase of the source strobes is unknown, so a count may be one off.
  task chk_rate(input string n, input int e);
    checked++;
    if (ns < e - 1 || ns > e + 1) begin
      failures++;
      $display("Error %s expected %0d seen %0d", n, e, ns);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1;
    do begin
      @(posedge sys_clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task meas(input int n);
    ns = 0;
    nc = 0;
    por = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      ns += (system_clock_out_o === 1'b1);
      nc += (core_clk_en_o === 1'b1);
      por |= periph_clk_en_o;
    end
  endtask
  task sleep(input logic d);
    @(posedge sys_clk_i);
    wfi_req_i <= 1;
    deepsleep_en_i <= d;
    @(posedge sys_clk_i);
    wfi_req_i <= 0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task wake_up();
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wake_irq_i <= 1;
    @(posedge sys_clk_i);
    wake_irq_i <= 0;
    while (mode_o !== SCC_RUN && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("mode_run", 32'h0, {30'h0, mode_o});
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 0;
    rdc("run_cfg_rst", `SCC_OFS_RUN_CFG, `SCC_RST_RUN_CFG);
    rdc("ext_cfg_rst", `SCC_OFS_RUN_CFG_EXT, `SCC_RST_RUN_CFG_EXT);
    rdc("gate_rst", `SCC_OFS_RUN_GATE, `SCC_RST_GATE);
    apb(0, 12'h004, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    apb(1, `SCC_OFS_RAW_STATUS, 32'h1);
    rdc("raw_ro", `SCC_OFS_RAW_STATUS, 32'h0);
    chk("pll_off", 32'h0, {31'h0, pll_enable_o});
    meas(120);
    chk_rate("reset_rate", 40);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      apb(1, `SCC_OFS_RUN_CFG_EXT, 32'h8000_0003 | {23'h0, srcs[i], 6'h0});
      repeat (20) @(posedge sys_clk_i);
      meas(120);
      chk_rate("src_rate", rts[i]);
    end
    $display("test sources done");
    apb(1, `SCC_OFS_IRQ_MASK, 32'h1);
    apb(1, `SCC_OFS_RUN_CFG_EXT, 32'h8000_0000);
    repeat (4) @(posedge sys_clk_i);
    chk("pll_on", 32'h1, {31'h0, pll_enable_o});
    chk("irq_relock", 32'h0, {31'h0, pll_lock_irq_o});
    meas(16);
    chk_rate("relock_rate", 8);
    rdc("raw_relock", `SCC_OFS_RAW_STATUS, 32'h0);
    repeat (30) @(posedge sys_clk_i);
    rdc("raw_lock", `SCC_OFS_RAW_STATUS, 32'h1);
    chk("irq_lock", 32'h1, {31'h0, pll_lock_irq_o});
    meas(120);
    chk_rate("pll_rate", 120);
    apb(1, `SCC_OFS_RUN_CFG_EXT, 32'h8000_0000);
    rdc("raw_same", `SCC_OFS_RAW_STATUS, 32'h1);
    apb(1, `SCC_OFS_RUN_CFG, 32'h0000_601B);
    repeat (4) @(posedge sys_clk_i);
    rdc("raw_crystal_select", `SCC_OFS_RAW_STATUS, 32'h0);
    chk("xlat_port", 32'h0743, {19'h0, pll_settings_o});
    apb(0, `SCC_OFS_PLL_XLAT, 32'h0);
    chk("xlat_reg", 32'h0743, {19'h0, rd[12:0]});
    repeat (50) @(posedge sys_clk_i);
    apb(1, `SCC_OFS_IRQ_CLEAR, 32'h1);
    repeat (3) @(posedge sys_clk_i);
    chk("irq_clear", 32'h0, {31'h0, pll_lock_irq_o});
    $display("test pll done");
    apb(1, `SCC_OFS_RUN_GATE, 32'h5);
    apb(1, `SCC_OFS_SLEEP_GATE, 32'h2);
    apb(1, `SCC_OFS_DSLEEP_GATE, 32'h8);
    meas(120);
    chk("run_gate", 32'h5, por);
    sleep(0);
    meas(120);
    chk("sleep_gate", 32'h2, por);
    chk("core_sleep", 32'h0, nc);
    chk_rate("sleep_rate", 120);
    wake_up();
    sleep(1);
    chk("ds_pll_off", 32'h0, {31'h0, pll_enable_o});
    chk("ds_main_crystal_oscillator_on", 32'h0, {31'h0, main_crystal_oscillator_power_down_o});
    meas(256);
    chk("ds_gate", 32'h8, por);
    chk_rate("ds_rate", 2);
    wake_up();
    chk("exit_pll", 32'h1, {31'h0, pll_enable_o});
    apb(1, `SCC_OFS_DSLEEP_CFG, 32'h10);
    sleep(1);
    chk("ds_internal_fast_oscillator_up", 32'h1, {31'h0, internal_fast_oscillator_power_up_o});
    chk("ds_main_crystal_oscillator_pd", 32'h1, {31'h0, main_crystal_oscillator_power_down_o});
    wake_up();
    apb(1, `SCC_OFS_RUN_CFG, 32'h0000_201B);
    sleep(0);
    meas(120);
    chk("sleep_nogate", 32'h5, por);
    wake_up();
    $display("test sleep done");
    test_done();
  end
endmodule

bind scc_top scc_top_sva #(.NPER(NPER)) i_sva (.sys_clk_i, .reset_i, .psel, .penable, .pready,
  .pslverr, .wfi_req_i, .deepsleep_en_i, .wake_irq_i, .system_clock_out_o, .core_clk_en_o,
  .periph_clk_en_o, .pll_enable_o, .mode_o);
